/* design/eis_edge_det.sv */
// Edge detector for one synchronous level with selectable polarity.
// Assumes the level is already filtered and synchronous to clk.
`timescale 1ns/10ps
module eis_edge_det
  import eis_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic level,
  input  wire logic rise_sel,
  input  wire logic enable,
  output logic      edge_pulse
);

  logic prev;
  logic armed;
  logic next_prev;
  logic next_armed;

  // No edge on the first sample after reset, whatever the pin shows
  always_comb begin
    next_prev  = level;
    next_armed = 1'b1;
  end

  // Previous sample
  always_ff @(posedge clk) begin
    if (rst) begin
      prev  <= PIN_IDLE;
      armed <= 1'b0;
    end else begin
      prev  <= next_prev;
      armed <= next_armed;
    end
  end

  // Polarity picks rising or falling transition
  assign edge_pulse = armed & enable & (rise_sel ? (level & ~prev) : (~level & prev));

endmodule

/* design/eis_filter.sv */
// Digital debounce filter for one pin.
// Assumes a synchronous input and a one-cycle sample tick from a divider.
`timescale 1ns/10ps
module eis_filter
  import eis_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              tick,
  input  wire logic              din,
  input  wire logic [FILT_W-1:0] setting,
  output logic                   dout
);

  logic [FILT_W-1:0] cnt;
  logic [FILT_W-1:0] next_cnt;
  logic              next_dout;

  // Outside bypass, output follows only after the input differs for setting+1 ticks
  always_comb begin
    next_cnt  = cnt;
    next_dout = dout;
    if (setting == FILT_BYPASS) begin
      // Bypass keeps the pin live while the tick source is stopped
      next_dout = din;
      next_cnt  = '0;
    end else if (din == dout) begin
      next_cnt = '0;
    end else if (tick) begin
      if (cnt >= setting) begin
        next_dout = din;
        next_cnt  = '0;
      end else begin
        next_cnt = cnt + 8'h01;
      end
    end
  end

  // Filter state
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt  <= '0;
      dout <= PIN_IDLE;
    end else begin
      cnt  <= next_cnt;
      dout <= next_dout;
    end
  end

  AST_FILT_BYPASS: assert property (@(posedge clk) disable iff (rst)
    (setting == FILT_BYPASS) |=> (dout == $past(din)))
    else $error("filter bypass does not follow input");

endmodule

/* design/eis_pkg.sv */
// Constants shared by the external and match interrupt source block.
// Assumes a word-aligned Avalon-MM register bus with 32-bit data.
package eis_pkg;

  // ****************************************************************
  // Register map (word index; byte address is four times the index)
  // ****************************************************************
  localparam int         ADDR_W     = 6;
  localparam logic [3:0] IDX_SELECT = 4'h0;
  localparam logic [3:0] IDX_FLAGS  = 4'h1;
  localparam logic [3:0] IDX_MODE2  = 4'h2;
  localparam logic [3:0] IDX_PORT   = 4'h3;
  localparam logic [3:0] IDX_FILT6  = 4'h4;
  localparam logic [3:0] IDX_FILTN  = 4'h5;
  localparam logic [3:0] IDX_KDIR   = 4'h6;
  localparam logic [3:0] IDX_MEN    = 4'h7;
  localparam logic [3:0] IDX_MADDR0 = 4'h8;
  localparam logic [3:0] IDX_MADDR1 = 4'h9;

  // ****************************************************************
  // Sizes and field positions
  // ****************************************************************
  localparam int NUM_EXT        = 6;
  localparam int NUM_KEY        = 4;
  localparam int NUM_MATCH      = 2;
  localparam int NUM_FLAGS      = 10;
  localparam int PC_W           = 20;
  localparam int FILT_W         = 8;
  localparam int ACC_ID_W       = 4;
  localparam int FIFTH_IDX      = 4;
  localparam int SIXTH_IDX      = 5;
  localparam int SEL_FIFTH_POS  = 6;
  localparam int SEL_SIXTH_POS  = 7;
  localparam int NMI_ENABLE_POS = 4;
  localparam int NMI_LEVEL_POS  = 5;
  localparam int KEY_DIR_LSB    = 4;
  localparam int FLG_NMI        = 6;
  localparam int FLG_KEY        = 7;
  localparam int FLG_MATCH0     = 8;
  localparam int FILT_TICK_DIV  = 16;

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [7:0]        SELECT_RST    = 8'h00;
  localparam logic [FILT_W-1:0] FILT_RST      = 8'h00;
  localparam logic [FILT_W-1:0] FILT_BYPASS   = 8'hff;
  localparam logic [3:0]        KDIR_RST      = 4'h0;
  localparam logic [1:0]        MEN_RST       = 2'h0;
  localparam logic [PC_W-1:0]   PC_RST        = 20'h00000;
  localparam logic [PC_W-1:0]   PC_STEP_LONG  = 20'h00002;
  localparam logic [PC_W-1:0]   PC_STEP_SHORT = 20'h00001;
  localparam logic [31:0]       READ_ZERO     = 32'h00000000;
  localparam logic              PIN_IDLE      = 1'b1;

endpackage

/* design/eis_top.sv */
// External pin, key and address match interrupt sources with register slave.
// Assumes synchronous pins, an Avalon-MM master, and a core that reports
// instruction starts and accepted interrupts as one-cycle pulses.
`timescale 1ns/10ps

// How it works
// - Six pin edges raise requests, per-pin polarity
// - Fifth and sixth pins routed only when selected
// - Sixth pin passes a debounce filter first
// - NMI falling edge requests only once enabled
// - NMI request ignores every mask and priority
// - NMI off after reset; only reset disables
// - NMI pin level readable in port register
// - NMI debounced; ff setting for stop wakeup
// - Low on any input-direction key pin requests
// - Key interrupt wakes from wait or stop
// - Held-low key pin masks other key falls
// - Match request before instruction at compare address
// - Each match channel has its own enable
// - Match requests ignore I flag and priority
// - Saved PC is compare address plus two or one
// - Accepting a request clears its flag
module eis_top
  import eis_pkg::*;
#(
  parameter int TICK_DIV = FILT_TICK_DIV
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic [ADDR_W-1:0]    avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire logic [NUM_EXT-1:0]   ext_irq_input,
  input  wire logic                 nmi_shared_port_pin,
  input  wire logic [NUM_KEY-1:0]   key_input_pins,
  input  wire logic                 fetch_valid,
  input  wire logic [PC_W-1:0]      fetch_addr,
  input  wire logic                 fetch_long_form,
  input  wire logic                 irq_accept,
  input  wire logic [ACC_ID_W-1:0]  irq_accept_id,
  output logic      [NUM_FLAGS-1:0] request_flag,
  output logic                      wakeup_req,
  output logic      [PC_W-1:0]      match_saved_pc
);

  // ****************************************************************
  // Register state
  // ****************************************************************
  logic [7:0]           ext_irq_select_reg;
  logic [FILT_W-1:0]    sixth_input_filter_reg;
  logic [FILT_W-1:0]    nmi_filter_reg;
  logic                 nmi_enable_bit;
  logic [NUM_KEY-1:0]   key_pin_direction_bits;
  logic [NUM_MATCH-1:0] match_enable_reg;
  logic [PC_W-1:0]      match_compare_addr [NUM_MATCH];

  logic [7:0]           next_select;
  logic [FILT_W-1:0]    next_filt6;
  logic [FILT_W-1:0]    next_filtn;
  logic                 next_nmi_en;
  logic [NUM_KEY-1:0]   next_kdir;
  logic [NUM_MATCH-1:0] next_men;
  logic [PC_W-1:0]      next_maddr [NUM_MATCH];
  logic [31:0]          next_readdata;
  logic                 next_waitrequest;

  logic                 wr_go;
  logic [3:0]           reg_idx;
  logic [NUM_FLAGS-1:0] sw_clear;

  // Merge written bytes into an old value by byte enable
  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] wdata,
                                        input logic [3:0]  be);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Avalon-MM slave: one wait cycle, then the access completes
  // ****************************************************************
  assign reg_idx = avs_address[ADDR_W-1:2];
  assign wr_go   = avs_write & ~avs_waitrequest;

  // Register writes and read mux
  always_comb begin
    next_select      = ext_irq_select_reg;
    next_filt6       = sixth_input_filter_reg;
    next_filtn       = nmi_filter_reg;
    next_nmi_en      = nmi_enable_bit;
    next_kdir        = key_pin_direction_bits;
    next_men         = match_enable_reg;
    next_maddr       = match_compare_addr;
    sw_clear         = '0;
    next_readdata    = avs_readdata;
    // Waitrequest drops for exactly one cycle per access
    next_waitrequest = ~((avs_read | avs_write) & avs_waitrequest);
    if (wr_go) begin
      unique case (reg_idx)
        IDX_SELECT: next_select = 8'(merge({24'h0, ext_irq_select_reg}, avs_writedata,
                                           avs_byteenable));
        IDX_FLAGS:  if (avs_byteenable[0]) begin
          sw_clear[7:0] = avs_writedata[7:0];
          if (avs_byteenable[1]) begin
            sw_clear[NUM_FLAGS-1:8] = avs_writedata[NUM_FLAGS-1:8];
          end
        end else if (avs_byteenable[1]) begin
          sw_clear[NUM_FLAGS-1:8] = avs_writedata[NUM_FLAGS-1:8];
        end
        // Set-only: a write of 0 cannot turn the NMI back off
        IDX_MODE2:  if (avs_byteenable[0] && avs_writedata[NMI_ENABLE_POS]) begin
          next_nmi_en = 1'b1;
        end
        IDX_FILT6:  if (avs_byteenable[0]) begin
          next_filt6 = avs_writedata[FILT_W-1:0];
        end
        IDX_FILTN:  if (avs_byteenable[0]) begin
          next_filtn = avs_writedata[FILT_W-1:0];
        end
        IDX_KDIR:   if (avs_byteenable[0]) begin
          next_kdir = avs_writedata[KEY_DIR_LSB +: NUM_KEY];
        end
        IDX_MEN:    if (avs_byteenable[0]) begin
          next_men = avs_writedata[NUM_MATCH-1:0];
        end
        IDX_MADDR0: next_maddr[0] = PC_W'(merge({12'h0, match_compare_addr[0]}, avs_writedata,
                                                avs_byteenable));
        IDX_MADDR1: next_maddr[1] = PC_W'(merge({12'h0, match_compare_addr[1]}, avs_writedata,
                                                avs_byteenable));
        default: ;
      endcase
    end
    // Read data is captured while waitrequest is high, stands at completion
    if (avs_read && avs_waitrequest) begin
      unique case (reg_idx)
        IDX_SELECT: next_readdata = {24'h0, ext_irq_select_reg};
        IDX_FLAGS:  next_readdata = {22'h0, request_flag};
        IDX_MODE2:  next_readdata = {27'h0, nmi_enable_bit, 4'h0};
        IDX_PORT:   next_readdata = {26'h0, nmi_shared_port_pin, 5'h00};
        IDX_FILT6:  next_readdata = {24'h0, sixth_input_filter_reg};
        IDX_FILTN:  next_readdata = {24'h0, nmi_filter_reg};
        IDX_KDIR:   next_readdata = {24'h0, key_pin_direction_bits, 4'h0};
        IDX_MEN:    next_readdata = {30'h0, match_enable_reg};
        IDX_MADDR0: next_readdata = {12'h0, match_compare_addr[0]};
        IDX_MADDR1: next_readdata = {12'h0, match_compare_addr[1]};
        default:    next_readdata = READ_ZERO;
      endcase
    end
  end

  // Register file and bus handshake
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_irq_select_reg     <= SELECT_RST;
      sixth_input_filter_reg <= FILT_RST;
      nmi_filter_reg         <= FILT_RST;
      nmi_enable_bit         <= 1'b0;
      key_pin_direction_bits <= KDIR_RST;
      match_enable_reg       <= MEN_RST;
      match_compare_addr[0]  <= PC_RST;
      match_compare_addr[1]  <= PC_RST;
      avs_readdata           <= READ_ZERO;
      avs_waitrequest        <= 1'b1;
    end else begin
      ext_irq_select_reg     <= next_select;
      sixth_input_filter_reg <= next_filt6;
      nmi_filter_reg         <= next_filtn;
      nmi_enable_bit         <= next_nmi_en;
      key_pin_direction_bits <= next_kdir;
      match_enable_reg       <= next_men;
      match_compare_addr     <= next_maddr;
      avs_readdata           <= next_readdata;
      avs_waitrequest        <= next_waitrequest;
    end
  end

  // ****************************************************************
  // Filter tick divider and debounce filters
  // ****************************************************************
  logic [15:0] tick_cnt;
  logic [15:0] next_tick_cnt;
  logic        tick;
  logic        sixth_filtered;
  logic        nmi_filtered;

  // One-cycle tick every TICK_DIV clocks
  always_comb begin
    tick          = (tick_cnt == 16'(TICK_DIV - 1));
    next_tick_cnt = tick ? '0 : tick_cnt + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  eis_filter u_filt_sixth (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .din     (ext_irq_input[SIXTH_IDX]),
    .setting (sixth_input_filter_reg),
    .dout    (sixth_filtered)
  );

  eis_filter u_filt_nmi (
    .clk     (clk),
    .rst     (rst),
    .tick    (tick),
    .din     (nmi_shared_port_pin),
    .setting (nmi_filter_reg),
    .dout    (nmi_filtered)
  );

  // ****************************************************************
  // Edge detection for pins, NMI and the key group
  // ****************************************************************
  logic [NUM_EXT-1:0] ext_level;
  logic [NUM_EXT-1:0] ext_route;
  logic [NUM_EXT-1:0] ext_edge;
  logic               nmi_edge;
  logic               key_low;
  logic               key_edge;

  // Sixth pin uses its filtered level; fifth and sixth need their select
  always_comb begin
    ext_level            = ext_irq_input;
    ext_level[SIXTH_IDX] = sixth_filtered;
    ext_route            = {NUM_EXT{1'b1}};
    ext_route[FIFTH_IDX] = ext_irq_select_reg[SEL_FIFTH_POS];
    ext_route[SIXTH_IDX] = ext_irq_select_reg[SEL_SIXTH_POS];
  end

  for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
    eis_edge_det u_edge (
      .clk        (clk),
      .rst        (rst),
      .level      (ext_level[i]),
      .rise_sel   (ext_irq_select_reg[i]),
      .enable     (ext_route[i]),
      .edge_pulse (ext_edge[i])
    );
  end

  eis_edge_det u_edge_nmi (
    .clk        (clk),
    .rst        (rst),
    .level      (nmi_filtered),
    .rise_sel   (1'b0),
    .enable     (nmi_enable_bit),
    .edge_pulse (nmi_edge)
  );

  // Wired-AND of input-direction pins: one held low hides the others
  assign key_low = |(~key_input_pins & ~key_pin_direction_bits);

  eis_edge_det u_edge_key (
    .clk        (clk),
    .rst        (rst),
    .level      (~key_low),
    .rise_sel   (1'b0),
    .enable     (1'b1),
    .edge_pulse (key_edge)
  );

  // ****************************************************************
  // Address match and request flags
  // ****************************************************************
  logic [NUM_MATCH-1:0] match_hit;
  logic [NUM_FLAGS-1:0] flag_set;
  logic [NUM_FLAGS-1:0] flag_clr;
  logic [NUM_FLAGS-1:0] next_flag;
  logic [PC_W-1:0]      next_saved_pc;
  logic                 next_wakeup;

  // Compare at instruction start; channel 0 wins the saved PC on a tie
  always_comb begin
    next_saved_pc = match_saved_pc;
    for (int m = 0; m < NUM_MATCH; m++) begin
      match_hit[m] = fetch_valid & match_enable_reg[m]
                     & (fetch_addr == match_compare_addr[m]);
    end
    for (int m = NUM_MATCH - 1; m >= 0; m--) begin
      if (match_hit[m]) begin
        next_saved_pc = match_compare_addr[m] +
                        (fetch_long_form ? PC_STEP_LONG : PC_STEP_SHORT);
      end
    end
  end

  // Sticky flags: a new event beats a clear in the same cycle
  always_comb begin
    flag_set                           = '0;
    flag_set[NUM_EXT-1:0]              = ext_edge;
    flag_set[FLG_NMI]                  = nmi_edge;
    flag_set[FLG_KEY]                  = key_edge;
    flag_set[FLG_MATCH0 +: NUM_MATCH]  = match_hit;
    flag_clr                           = sw_clear;
    if (irq_accept && (32'(irq_accept_id) < NUM_FLAGS)) begin
      flag_clr[irq_accept_id] = 1'b1;
    end
    next_flag   = flag_set | (request_flag & ~flag_clr);
    // Wake request follows the key flag so wait and stop both exit
    next_wakeup = next_flag[FLG_KEY];
  end

  // Flags, wakeup and saved PC
  always_ff @(posedge clk) begin
    if (rst) begin
      request_flag   <= '0;
      wakeup_req     <= 1'b0;
      match_saved_pc <= PC_RST;
    end else begin
      request_flag   <= next_flag;
      wakeup_req     <= next_wakeup;
      match_saved_pc <= next_saved_pc;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_accept_quiet(int k);
    irq_accept && (irq_accept_id == ACC_ID_W'(k)) && !flag_set[k];
  endsequence

  AST_NMI_STAYS_ON: assert property (nmi_enable_bit |=> nmi_enable_bit)
    else $error("nmi enable dropped without reset");

  AST_NMI_NEEDS_EN: assert property ($rose(request_flag[FLG_NMI]) |-> $past(nmi_enable_bit))
    else $error("nmi request while disabled");

  AST_EXT_SETS: assert property ((ext_edge != '0) |=>
    ((request_flag[NUM_EXT-1:0] & $past(ext_edge)) == $past(ext_edge)))
    else $error("pin edge did not set its flag");

  AST_ROUTE_GATE: assert property (!ext_irq_select_reg[SEL_FIFTH_POS] |-> !ext_edge[FIFTH_IDX])
    else $error("fifth pin edge while not routed");

  AST_KEY_OUT_IGNORED: assert property ((key_pin_direction_bits == 4'hf) |-> !key_low)
    else $error("output key pins raised key request");

  AST_MATCH_EN: assert property ($rose(request_flag[FLG_MATCH0]) |-> $past(match_enable_reg[0]))
    else $error("match request from disabled channel");

  AST_MATCH_PC: assert property ((match_hit[0] && fetch_long_form) |=>
    (match_saved_pc == $past(match_compare_addr[0]) + PC_STEP_LONG) && request_flag[FLG_MATCH0])
    else $error("wrong saved pc on match");

  AST_ACCEPT_CLEARS: assert property (s_accept_quiet(FLG_KEY) |=> !request_flag[FLG_KEY] ##1
    (wakeup_req == request_flag[FLG_KEY]))
    else $error("accepted flag not cleared");

  AST_SET_WINS: assert property ((flag_set != '0) |=>
    ((request_flag & $past(flag_set)) == $past(flag_set)))
    else $error("clear beat a new event");

endmodule

/* dv/eis_pins_model.sv */
// Far side model: external pins, key pins and processor core pulses.
// Assumes the bench calls its tasks from the clk domain, one at a time.
`timescale 1ns/10ps
module eis_pins_model
  import eis_pkg::*;
(
  input  wire logic                clk,
  output logic     [NUM_EXT-1:0]   ext_irq_input,
  output logic                     nmi_shared_port_pin,
  output logic     [NUM_KEY-1:0]   key_input_pins,
  output logic                     fetch_valid,
  output logic     [PC_W-1:0]      fetch_addr,
  output logic                     fetch_long_form,
  output logic                     irq_accept,
  output logic     [ACC_ID_W-1:0]  irq_accept_id
);
  // Idle levels; pins rest high like pulled-up lines
  initial begin
    ext_irq_input = {NUM_EXT{PIN_IDLE}};
    nmi_shared_port_pin = PIN_IDLE;
    key_input_pins = {NUM_KEY{PIN_IDLE}};
    fetch_valid = 1'b0;
    fetch_addr = PC_RST;
    fetch_long_form = 1'b0;
    irq_accept = 1'b0;
    irq_accept_id = '0;
  end
  // Digital levels only; key pins never used as analog inputs
  task automatic pins(input logic [5:0] e, input logic n, input logic [3:0] k);
    @(posedge clk);
    ext_irq_input <= e;
    nmi_shared_port_pin <= n;
    key_input_pins <= k;
  endtask
  // One-cycle start pulse; address is always an instruction's first byte
  task automatic fetch(input logic [PC_W-1:0] a, input logic lng);
    @(posedge clk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    fetch_long_form <= lng;
    @(posedge clk);
    fetch_valid <= 1'b0;
    fetch_addr <= ~a; // Stale address must not matter
    fetch_long_form <= ~lng;
  endtask
  // One-cycle accept pulse from the interrupt sequencer
  task automatic accept(input logic [ACC_ID_W-1:0] id);
    @(posedge clk);
    irq_accept <= 1'b1;
    irq_accept_id <= id;
    @(posedge clk);
    irq_accept <= 1'b0;
    irq_accept_id <= ~id;
  endtask
endmodule

/* dv/test_external_and_match_interrupt_sources.sv */
// Self-checking bench for the interrupt source block.
// Assumes the far side model above and a short filter tick for speed.
`timescale 1ns/10ps
module test_external_and_match_interrupt_sources
  import eis_pkg::*;
;
  logic                  clk;
  logic                  rst;
  logic [ADDR_W-1:0]     avs_address;
  logic                  avs_read;
  logic                  avs_write;
  logic [31:0]           avs_writedata;
  logic [31:0]           avs_readdata;
  logic                  avs_waitrequest;
  logic [NUM_EXT-1:0]    ext_irq_input;
  logic                  nmi_shared_port_pin;
  logic [NUM_KEY-1:0]    key_input_pins;
  logic                  fetch_valid;
  logic [PC_W-1:0]       fetch_addr;
  logic                  fetch_long_form;
  logic                  irq_accept;
  logic [ACC_ID_W-1:0]   irq_accept_id;
  logic [NUM_FLAGS-1:0]  request_flag;
  logic                  wakeup_req;
  logic [PC_W-1:0]       match_saved_pc;
  logic [31:0]           rd;
  int                    num_errors = 0;
  int                    num_checks = 0;

  // ****************************************************************
  // Design, far side and clock
  // ****************************************************************
  // Short tick keeps filter delays to a few cycles
  eis_top #(.TICK_DIV(2)) eis_top_inst (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_irq_input(ext_irq_input), .nmi_shared_port_pin(nmi_shared_port_pin),
    .key_input_pins(key_input_pins), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
    .fetch_long_form(fetch_long_form), .irq_accept(irq_accept),
    .irq_accept_id(irq_accept_id), .request_flag(request_flag), .wakeup_req(wakeup_req),
    .match_saved_pc(match_saved_pc));
  eis_pins_model eis_pins_model_inst (.clk(clk), .ext_irq_input(ext_irq_input),
    .nmi_shared_port_pin(nmi_shared_port_pin), .key_input_pins(key_input_pins),
    .fetch_valid(fetch_valid), .fetch_addr(fetch_addr), .fetch_long_form(fetch_long_form),
    .irq_accept(irq_accept), .irq_accept_id(irq_accept_id));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ****************************************************************
  // Bus, compare and closing tasks
  // ****************************************************************
  // One access; request held until waitrequest is seen low
  // Only the watchdog ends a wait that never completes
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] d);
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    avs_writedata <= ~d;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdchk(input logic [3:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h00000000);
    check("readdata", exp, rd);
  endtask
  // Settle past the filter and edge delays, then compare flags
  task automatic flags(input logic [9:0] exp);
    repeat (30) @(posedge clk);
    check("request_flag", {22'h000000, exp}, {22'h000000, request_flag});
  endtask
  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cuts a hang short; the full run takes under 2000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdchk(IDX_MODE2, 32'h00000000);
    rdchk(4'hf, READ_ZERO);
    eis_pins_model_inst.pins(6'h3e, 1'b1, 4'hf);
    bus(1'b1, IDX_SELECT, 32'h00000001);
    bus(1'b1, IDX_FLAGS, 32'h000003ff);
    eis_pins_model_inst.pins(6'h01, 1'b1, 4'hf);
    flags(10'h00f);
    eis_pins_model_inst.pins(6'h3e, 1'b1, 4'hf);
    flags(10'h00f);
    bus(1'b1, IDX_SELECT, 32'h000000c1);
    bus(1'b1, IDX_FLAGS, 32'h000003ff);
    rdchk(IDX_FLAGS, 32'h00000000);
    eis_pins_model_inst.pins(6'h01, 1'b1, 4'hf);
    flags(10'h03f);
    eis_pins_model_inst.accept(4'h5);
    flags(10'h01f);
    eis_pins_model_inst.pins(6'h01, 1'b0, 4'hf);
    flags(10'h01f);
    rdchk(IDX_PORT, 32'h00000000);
    bus(1'b1, IDX_FILTN, 32'h000000ff);
    bus(1'b1, IDX_MODE2, 32'h00000010);
    bus(1'b1, IDX_MODE2, 32'h00000000);
    rdchk(IDX_MODE2, 32'h00000010);
    eis_pins_model_inst.pins(6'h01, 1'b1, 4'hf);
    rdchk(IDX_PORT, 32'h00000020);
    eis_pins_model_inst.pins(6'h01, 1'b0, 4'hf);
    flags(10'h05f);
    bus(1'b1, IDX_KDIR, 32'h00000080);
    eis_pins_model_inst.pins(6'h01, 1'b0, 4'h7);
    flags(10'h05f);
    eis_pins_model_inst.pins(6'h01, 1'b0, 4'h6);
    flags(10'h0df);
    check("wakeup_req", 32'h00000001, {31'h00000000, wakeup_req});
    eis_pins_model_inst.accept(4'h7);
    eis_pins_model_inst.pins(6'h01, 1'b0, 4'h4);
    flags(10'h05f);
    check("wakeup_req", 32'h00000000, {31'h00000000, wakeup_req});
    bus(1'b1, IDX_MADDR0, 32'h00012344);
    bus(1'b1, IDX_MADDR1, 32'h0000abcd);
    bus(1'b1, IDX_MEN, 32'h00000001);
    eis_pins_model_inst.fetch(20'h0abcd, 1'b1);
    flags(10'h05f);
    eis_pins_model_inst.fetch(20'h12344, 1'b1);
    flags(10'h15f);
    check("match_saved_pc", 32'h00012346, {12'h000, match_saved_pc});
    bus(1'b1, IDX_MEN, 32'h00000003);
    eis_pins_model_inst.fetch(20'h0abcd, 1'b0);
    flags(10'h35f);
    check("match_saved_pc", 32'h0000abce, {12'h000, match_saved_pc});
    // Sixth filter set to bypass as software must before stop; one-cycle pulse passes
    bus(1'b1, IDX_FILT6, 32'h000000ff);
    rdchk(IDX_FILT6, 32'h000000ff);
    eis_pins_model_inst.pins(6'h21, 1'b0, 4'h4);
    eis_pins_model_inst.pins(6'h01, 1'b0, 4'h4);
    flags(10'h37f);
    // Handler takes match 0; fixing the stacked return address is software's job
    eis_pins_model_inst.accept(4'h8);
    flags(10'h27f);
    conclude();
  end
endmodule
